// ==== inc/cdd_regs.svh ====
// Constants of the clock divider and sync distribution block.
// Assumes nothing; definitions only, included by package and modules.
`ifndef CDD_REGS_SVH
`define CDD_REGS_SVH

// Serial word layout
`define CDD_WORD_BITS      32
`define CDD_DATA_BITS      27
`define CDD_ADDR_BITS      5
`define CDD_ADDR_MSB       4
`define CDD_DATA_LSB       5
`define CDD_WORD_MSB       31
// Fields inside a pair word (word bit positions)
`define CDD_DIV_MSB        15
`define CDD_DIV_LSB        5
`define CDD_EXEMPT_BIT     16
`define CDD_RESET_BIT      17
// Reference buffer word
`define CDD_OSC_DIV_MSB    7
`define CDD_OSC_DIV_LSB    5
`define CDD_OSC_SEL_A_BIT  8
`define CDD_OSC_SEL_B_BIT  9
// Sync word
`define CDD_SYNC_INV_BIT   5
// Serial addresses
`define CDD_ADDR_PAIR0     5'h00
`define CDD_ADDR_OSC       5'h0a
`define CDD_ADDR_SYNC      5'h0b
// Divider limits and start-up values
`define CDD_DIV_W          11
`define CDD_DIV_MAX        11'h415
`define CDD_DIV_EXT        11'h01a
`define CDD_STARTUP_DIV    11'h019
`define CDD_STARTUP_PAIR   4
`define CDD_STARTUP_LANE   8
`define CDD_PAIRS          6
`define CDD_LANES          12
// Feedback path
`define CDD_FB_PRESCALE    2
`define CDD_FB_N           50
// Wishbone byte offsets and register bit positions
`define CDD_WB_CTRL        8'h00
`define CDD_WB_STATUS      8'h04
`define CDD_WB_SHIFT       8'h08
`define CDD_WB_CFG_BASE    8'h80
`define CDD_CTRL_EXT_REF   0
`define CDD_ST_PROG        0
`define CDD_ST_SYNC        1
`define CDD_ST_EXT_LSB     2
`define CDD_ST_ADDR_LSB    8

`endif

// ==== inc/cdd_pkg.sv ====
// Types and small helpers of the clock divider and sync distribution block.
// Assumes cdd_regs.svh is on the include path.
`include "cdd_regs.svh"
package cdd_pkg;

  // One system clock cycle split in two halves, first half first
  typedef struct packed {
    logic first_half;
    logic second_half;
  } cdd_half_pair_type;

  typedef logic [`CDD_DIV_W-1:0]     cdd_div_type;
  typedef logic [`CDD_DATA_BITS-1:0] cdd_data_type;

  // Zero would stall the counter, so it acts as divide by one
  function automatic cdd_div_type cdd_safe_div(input cdd_div_type value);
    begin
      if (value == '0)
        cdd_safe_div = cdd_div_type'(1);
      else if (value > `CDD_DIV_MAX)
        cdd_safe_div = `CDD_DIV_MAX;
      else
        cdd_safe_div = value;
    end
  endfunction : cdd_safe_div

  function automatic cdd_data_type cdd_default_cfg(input int idx);
    logic [`CDD_WORD_MSB:0] word;
    begin
      word = '0;
      if (idx == `CDD_STARTUP_PAIR)
        word[`CDD_DIV_MSB:`CDD_DIV_LSB] = `CDD_STARTUP_DIV;
      else if (idx < `CDD_PAIRS)
        word[`CDD_DIV_MSB:`CDD_DIV_LSB] = cdd_div_type'(1);
      cdd_default_cfg = word[`CDD_WORD_MSB:`CDD_DATA_LSB];
    end
  endfunction : cdd_default_cfg

endpackage : cdd_pkg

// ==== logic/cdd_out_divider.sv ====
// One programmable output divider with half-cycle resolution.
// Assumes a divide value that is held stable by the caller; it is taken at wrap.
`timescale 1ns/1ps
`include "cdd_regs.svh"
module cdd_out_divider (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  input  wire logic                      hold,
  input  wire cdd_pkg::cdd_div_type      div_value,
  output cdd_pkg::cdd_half_pair_type     clk_out,
  output logic                           ext_mode
);

  logic [`CDD_DIV_W:0]  half_ff;
  cdd_pkg::cdd_div_type div_ff;
  logic [`CDD_DIV_W:0]  period_half;
  logic [`CDD_DIV_W:0]  nxt_half;
  logic                 wrap;

  // Count in half cycles so odd divides still give exact 50% duty
  always_comb
  begin
    period_half = {div_ff, 1'b0};
    wrap        = (half_ff + (`CDD_DIV_W+1)'(2)) >= period_half;
    nxt_half    = wrap ? '0 : half_ff + (`CDD_DIV_W+1)'(2);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst || hold)
    begin
      half_ff <= '0;
      div_ff  <= cdd_pkg::cdd_safe_div(div_value);
    end
    else
    begin
      half_ff <= nxt_half;
      if (wrap)
        div_ff <= cdd_pkg::cdd_safe_div(div_value);
    end
  end

  // Held divider stays low; restart from zero gives a common rising edge
  always_ff @(posedge clk_sys)
  begin
    if (rst || hold)
      clk_out <= '0;
    else
    begin
      clk_out.first_half  <= half_ff < {1'b0, div_ff};
      clk_out.second_half <= (half_ff + (`CDD_DIV_W+1)'(1)) < {1'b0, div_ff};
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      ext_mode <= 1'b0;
    else
      ext_mode <= div_ff >= `CDD_DIV_EXT;
  end

endmodule : cdd_out_divider

// ==== logic/cdd_top.sv ====
// Clock divider and sync distribution: serial config port, six pair dividers,
// reference buffer divider, sync, start-up clocks and a Wishbone register slave.
// Assumes all pins are synchronous to clk_sys, which stands for the oscillator.
//
// Register access over Wishbone and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "cdd_regs.svh"
// Function
// - Sample serial data into shift register on each serial clock rising edge.
// - Latch-enable rising edge copies shift register into the addressed register.
// - Output dividers take any value 1 to 1045 with 50% duty.
// - Six dividers each drive an output pair, twelve outputs in all.
// - Divide values of 26 or more select extended counting mode.
// - Reference buffer divider divides reference input by 1 to 8.
// - Each reference buffer output selects divided or undivided reference.
// - Sync forces reference buffer outputs low, independent of divided clocks.
// - Sync-exempt pairs keep running through sync; phase may shift.
// - Sync realigns all active divided outputs to a common rising edge.
// - Toggling sync polarity invert through serial port makes a sync event.
// - Unprogrammed with crystal: only start-up output runs, oscillator divided by 25.
// - Unprogrammed with external oscillator: first reference output also passes reference.
// - Start-up output may stop or glitch during calibration after programming.
// - Oscillator feeds distribution and a prescaler plus N counter feedback path.
// - 32-bit word, MSB first, data bits 31..5, address bits 4..0.
// - Register zero write with reset bit set restores defaults, ignores rest.
module cdd_top (
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  input  wire logic                        cfg_serial_clock,
  input  wire logic                        cfg_serial_data_in,
  input  wire logic                        cfg_latch_enable,
  input  wire logic                        sync_pin,
  input  wire logic                        reference_input,
  input  wire logic                        wb_cyc,
  input  wire logic                        wb_stb,
  input  wire logic                        wb_we,
  input  wire logic [7:0]                  wb_adr,
  input  wire logic [3:0]                  wb_sel,
  input  wire logic [31:0]                 wb_dat_w,
  output logic [31:0]                      wb_dat_r,
  output logic                             wb_ack,
  output cdd_pkg::cdd_half_pair_type       divided_clock_output [`CDD_LANES],
  output cdd_pkg::cdd_half_pair_type       ref_buffer_out_a,
  output cdd_pkg::cdd_half_pair_type       ref_buffer_out_b,
  output cdd_pkg::cdd_half_pair_type       pll_feedback_out
);

  logic [`CDD_WORD_MSB:0]     shift_ff;
  logic                       sclk_prev_ff;
  logic                       le_prev_ff;
  cdd_pkg::cdd_data_type      cfg_ff [2**`CDD_ADDR_BITS];
  logic                       programmed_ff;
  logic [`CDD_ADDR_BITS-1:0]  last_addr_ff;
  logic                       ext_ref_ff;
  logic                       sync_active;
  logic [`CDD_PAIRS-1:0]      exempt;
  logic [`CDD_PAIRS-1:0]      ext_mode;
  cdd_pkg::cdd_half_pair_type pair_clk [`CDD_PAIRS];
  logic                       ref_prev_ff;
  logic [2:0]                 ref_cnt_ff;
  logic                       ref_div_ff;
  logic [2:0]                 osc_div_m1;
  logic [`CDD_WORD_MSB:0]     sync_word;
  logic [`CDD_WORD_MSB:0]     osc_word;
  logic [`CDD_WORD_MSB:0]     pair_word [`CDD_PAIRS];
  logic                       sel_a;
  logic                       sel_b;
  logic                       commit;
  logic [`CDD_ADDR_BITS-1:0]  commit_addr;
  logic                       wb_req;
  logic [31:0]                nxt_rdata;

  // Word-bit view of a stored register
  function automatic logic [`CDD_WORD_MSB:0] word_of(input cdd_pkg::cdd_data_type d);
    begin
      word_of = {d, `CDD_ADDR_BITS'(0)};
    end
  endfunction : word_of

  // Serial port sampled on clk_sys; edges found from the previous sample
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sclk_prev_ff <= 1'b0;
      le_prev_ff   <= 1'b0;
    end
    else
    begin
      sclk_prev_ff <= cfg_serial_clock;
      le_prev_ff   <= cfg_latch_enable;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      shift_ff <= '0;
    else if (cfg_serial_clock && !sclk_prev_ff)
      shift_ff <= {shift_ff[`CDD_WORD_MSB-1:0], cfg_serial_data_in};
  end

  assign commit      = cfg_latch_enable && !le_prev_ff;
  assign commit_addr = shift_ff[`CDD_ADDR_MSB:0];

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      for (int i = 0; i < 2**`CDD_ADDR_BITS; i++)
        cfg_ff[i] <= cdd_pkg::cdd_default_cfg(i);
      programmed_ff <= 1'b0;
      last_addr_ff  <= '0;
    end
    else if (commit)
    begin
      last_addr_ff <= commit_addr;
      if (commit_addr == `CDD_ADDR_PAIR0 && shift_ff[`CDD_RESET_BIT])
      begin
        for (int i = 0; i < 2**`CDD_ADDR_BITS; i++)
          cfg_ff[i] <= cdd_pkg::cdd_default_cfg(i);
        programmed_ff <= 1'b0;
      end
      else
      begin
        cfg_ff[commit_addr] <= shift_ff[`CDD_WORD_MSB:`CDD_DATA_LSB];
        programmed_ff       <= 1'b1;
      end
    end
  end

  assign sync_word   = word_of(cfg_ff[`CDD_ADDR_SYNC]);
  assign osc_word    = word_of(cfg_ff[`CDD_ADDR_OSC]);

  // Either edge of the polarity bit flips the level and so frames a sync
  assign sync_active = sync_pin ^ sync_word[`CDD_SYNC_INV_BIT];

  // Six pair dividers straight off the oscillator clock
  genvar p;
  generate
    for (p = 0; p < `CDD_PAIRS; p++)
    begin : g_pair
      assign pair_word[p] = word_of(cfg_ff[p]);
      assign exempt[p]    = pair_word[p][`CDD_EXEMPT_BIT];
      cdd_out_divider u_div (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .hold      (sync_active && !exempt[p]),
        .div_value (pair_word[p][`CDD_DIV_MSB:`CDD_DIV_LSB]),
        .clk_out   (pair_clk[p]),
        .ext_mode  (ext_mode[p])
      );
    end
  endgenerate

  // Before programming only the start-up lane runs; re-commits may glitch it
  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < `CDD_LANES; i++)
    begin
      if (rst)
        divided_clock_output[i] <= '0;
      else if (programmed_ff || i == `CDD_STARTUP_LANE)
        divided_clock_output[i] <= pair_clk[i/2];
      else
        divided_clock_output[i] <= '0;
    end
  end

  // Feedback path: prescaler times N counter on the oscillator clock
  cdd_out_divider u_fb (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .hold      (1'b0),
    .div_value (cdd_pkg::cdd_div_type'(`CDD_FB_PRESCALE * `CDD_FB_N)),
    .clk_out   (pll_feedback_out),
    .ext_mode  ()
  );

  // Reference divider counts both input edges, so odd divides keep 50% duty
  assign osc_div_m1 = osc_word[`CDD_OSC_DIV_MSB:`CDD_OSC_DIV_LSB];
  assign sel_a      = osc_word[`CDD_OSC_SEL_A_BIT];
  assign sel_b      = osc_word[`CDD_OSC_SEL_B_BIT];

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ref_prev_ff <= 1'b0;
      ref_cnt_ff  <= '0;
      ref_div_ff  <= 1'b0;
    end
    else
    begin
      ref_prev_ff <= reference_input;
      if (reference_input != ref_prev_ff)
      begin
        if (ref_cnt_ff >= osc_div_m1)
        begin
          ref_cnt_ff <= '0;
          ref_div_ff <= !ref_div_ff;
        end
        else
          ref_cnt_ff <= ref_cnt_ff + 3'h1;
      end
    end
  end

  // Buffer outputs ignore pair exemption: they drop on any sync
  always_ff @(posedge clk_sys)
  begin
    if (rst || sync_active)
    begin
      ref_buffer_out_a <= '0;
      ref_buffer_out_b <= '0;
    end
    else if (!programmed_ff)
    begin
      ref_buffer_out_a <= ext_ref_ff ? {reference_input, reference_input} : '0;
      ref_buffer_out_b <= '0;
    end
    else
    begin
      ref_buffer_out_a <= sel_a ? {ref_div_ff, ref_div_ff}
                                : {reference_input, reference_input};
      ref_buffer_out_b <= sel_b ? {ref_div_ff, ref_div_ff}
                                : {reference_input, reference_input};
    end
  end

  // Wishbone classic slave: ack one cycle after the request, then drop
  assign wb_req = wb_cyc && wb_stb && !wb_ack;

  always_comb
  begin
    nxt_rdata = '0;
    if (wb_adr >= `CDD_WB_CFG_BASE)
      nxt_rdata = word_of(cfg_ff[wb_adr[2+:`CDD_ADDR_BITS]]);
    else
    begin
      case (wb_adr)
        `CDD_WB_CTRL:
          nxt_rdata[`CDD_CTRL_EXT_REF] = ext_ref_ff;
        `CDD_WB_STATUS:
        begin
          nxt_rdata[`CDD_ST_PROG] = programmed_ff;
          nxt_rdata[`CDD_ST_SYNC] = sync_active;
          nxt_rdata[`CDD_ST_EXT_LSB +: `CDD_PAIRS] = ext_mode;
          nxt_rdata[`CDD_ST_ADDR_LSB +: `CDD_ADDR_BITS] = last_addr_ff;
        end
        `CDD_WB_SHIFT:
          nxt_rdata = shift_ff;
        default:
          nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wb_ack   <= 1'b0;
      wb_dat_r <= '0;
    end
    else
    begin
      wb_ack   <= wb_req;
      wb_dat_r <= wb_req && !wb_we ? nxt_rdata : '0;
    end
  end

  // Tells the start-up logic whether the reference is an oscillator
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      ext_ref_ff <= 1'b0;
    else if (wb_req && wb_we && wb_sel[0] && wb_adr == `CDD_WB_CTRL)
      ext_ref_ff <= wb_dat_w[`CDD_CTRL_EXT_REF];
  end

endmodule : cdd_top

// ==== tb/cdd_host_model.sv ====
// Host model that shifts 32-bit words into the serial config port.
// Assumes start is a one-cycle pulse given only while busy is low.
`timescale 1ns/1ps
module cdd_host_model (
  input  wire logic        clk_sys,
  input  wire logic        start,
  input  wire logic [31:0] word,
  output logic             sclk,
  output logic             sdat,
  output logic             latch,
  output logic             busy
);
  initial {sclk, sdat, latch, busy} = 4'h0;
  // Each level stands two cycles so the block sees every edge
  always
  begin
    @(posedge clk_sys);
    if (start)
    begin
      busy <= 1'b1;
      for (int i = 31; i >= 0; i--)
      begin
        sdat <= word[i];
        repeat (2) @(posedge clk_sys);
        sclk <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sclk <= 1'b0;
      end
      repeat (2) @(posedge clk_sys);
      latch <= 1'b1;
      repeat (2) @(posedge clk_sys);
      {latch, sdat, busy} <= 3'h0;
    end
  end
endmodule : cdd_host_model

// ==== tb/cdd_top_assertions.sv ====
// Checker on the ports of cdd_top, bound below.
// Assumes pair 0 is never sync exempt and the invert bit is 0 while sync_pin is high.
`timescale 1ns/1ps
`include "cdd_regs.svh"
module cdd_top_assertions (
  input wire logic                  clk_sys,
  input wire logic                  rst,
  input wire logic                  cfg_latch_enable,
  input wire logic                  sync_pin,
  input wire logic                  wb_cyc,
  input wire logic                  wb_stb,
  input wire logic [31:0]           wb_dat_r,
  input wire logic                  wb_ack,
  input wire cdd_pkg::cdd_half_pair_type divided_clock_output [`CDD_LANES],
  input wire cdd_pkg::cdd_half_pair_type ref_buffer_out_a,
  input wire cdd_pkg::cdd_half_pair_type ref_buffer_out_b,
  input wire cdd_pkg::cdd_half_pair_type pll_feedback_out
);
  logic       seen_ff;
  logic       fb_ff;
  logic [6:0] run_ff;
  logic [1:0] chg_ff;
  wire        fb_chg = pll_feedback_out.first_half != fb_ff;
  always_ff @(posedge clk_sys)
    seen_ff <= !rst && (seen_ff || cfg_latch_enable);
  always_ff @(posedge clk_sys)
    fb_ff <= pll_feedback_out.first_half;
  // Half-period length of the feedback clock
  always_ff @(posedge clk_sys)
    run_ff <= (rst || fb_chg) ? 7'h01 : run_ff + 7'h01;
  always_ff @(posedge clk_sys)
    chg_ff <= rst ? 2'h0 : chg_ff + 2'((fb_chg && chg_ff != 2'h3) ? 1 : 0);

  a_ack_one_cycle: assert property (@(posedge clk_sys) disable iff (rst)
    wb_ack |=> !wb_ack) else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (@(posedge clk_sys) disable iff (rst)
    wb_ack |-> $past(wb_cyc && wb_stb)) else $error("ack without request");
  a_dat_idle_zero: assert property (@(posedge clk_sys) disable iff (rst)
    !wb_ack |-> wb_dat_r == 32'h0000_0000) else $error("read data outside ack");
  a_reset_quiet: assert property (@(posedge clk_sys)
    rst |=> !wb_ack && ref_buffer_out_a == 2'h0) else $error("output live in reset");
  a_sync_ref_low: assert property (@(posedge clk_sys) disable iff (rst)
    sync_pin [*4] |-> ref_buffer_out_a == 2'h0 && ref_buffer_out_b == 2'h0)
    else $error("reference output runs in sync");
  a_sync_div_low: assert property (@(posedge clk_sys) disable iff (rst)
    sync_pin [*4] |-> divided_clock_output[0] == 2'h0) else $error("synced lane runs");
  a_lane_pair_same: assert property (@(posedge clk_sys) disable iff (rst)
    divided_clock_output[0] == divided_clock_output[1]) else $error("pair lanes differ");
  a_unprog_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    !seen_ff |-> divided_clock_output[0] == 2'h0 && ref_buffer_out_b == 2'h0)
    else $error("output runs before programming");
  a_fb_half_period: assert property (@(posedge clk_sys) disable iff (rst)
    fb_chg && chg_ff != 2'h0 |-> run_ff == 7'h32) else $error("feedback half period");
endmodule : cdd_top_assertions

bind cdd_top cdd_top_assertions u_cdd_top_assertions (.clk_sys, .rst, .cfg_latch_enable,
  .sync_pin, .wb_cyc, .wb_stb, .wb_dat_r, .wb_ack, .divided_clock_output,
  .ref_buffer_out_a, .ref_buffer_out_b, .pll_feedback_out);

// ==== tb/tb_top.sv ====
// Self-checking bench for cdd_top with a serial host model and Wishbone tasks.
// Assumes a 10 MHz clk_sys and a reference input of one sixth of that rate.
`timescale 1ns/1ps
`include "cdd_regs.svh"
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("unexpected %s exp %0h got %0h", nm, exp, got); end end
module tb_top;
  logic        clk_sys, rst, sync_pin, reference_input, start, busy;
  logic        sclk, sdat, latch, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r, word;
  logic [2:0]  rc;
  int          n_mismatch, tests_run;
  cdd_pkg::cdd_half_pair_type lanes [`CDD_LANES];
  cdd_pkg::cdd_half_pair_type ref_a, ref_b;

  cdd_top u_cdd_top (.clk_sys, .rst, .cfg_serial_clock(sclk), .cfg_serial_data_in(sdat),
    .cfg_latch_enable(latch), .sync_pin, .reference_input, .wb_cyc, .wb_stb, .wb_we,
    .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .divided_clock_output(lanes),
    .ref_buffer_out_a(ref_a), .ref_buffer_out_b(ref_b), .pll_feedback_out());
  cdd_host_model u_cdd_host_model (.clk_sys, .start, .word, .sclk, .sdat, .latch, .busy);

  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    rc <= (rc == 3'h5) ? 3'h0 : rc + 3'h1;
    reference_input <= rc < 3'h3;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  task automatic wait_fail(input int n, input int lim);
    if (n >= lim)
    begin
      n_mismatch++;
      $display("unexpected timeout");
      end_of_test;
    end
  endtask : wait_fail

  // Classic cycle: request held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a, output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel} <= {2'b11, we, a, 4'h1};
    wb_dat_w <= 32'h0000_0001;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (wb_ack !== 1'b1 && n < 20);
    q = wb_dat_r;
    {wb_cyc, wb_stb} <= 2'b00;
    wait_fail(n, 20);
  endtask : wb

  task automatic send(input logic [31:0] w);
    int n;
    @(posedge clk_sys);
    word <= w;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (busy !== 1'b0 && n < 400);
    wait_fail(n, 400);
    repeat (4) @(posedge clk_sys);
  endtask : send

  function automatic cdd_pkg::cdd_half_pair_type pick(input int s);
    return s < 12 ? lanes[s] : (s == 12 ? ref_a : ref_b);
  endfunction : pick

  // High halves and rising edges of one output over c cycles
  task automatic meas(input int s, input int c, output int hi, output int ri);
    cdd_pkg::cdd_half_pair_type v;
    logic p;
    hi = 0;
    ri = 0;
    repeat (5) @(posedge clk_sys);
    v = pick(s);
    p = v.second_half;
    repeat (c)
    begin
      @(posedge clk_sys);
      v = pick(s);
      `CHK("output known", 1'b0, $isunknown(v))
      hi += v.first_half + v.second_half;
      ri += (v.first_half & !p) + (v.second_half & !v.first_half);
      p = v.second_half;
    end
  endtask : meas

  task automatic t_startup;
    int h, r;
    logic [31:0] q;
    meas(8, 250, h, r);
    `CHK("startup rises", 10, r)
    `CHK("startup duty", 250, h)
    meas(0, 100, h, r);
    `CHK("lane0 idle", 0, r)
    meas(12, 60, h, r);
    `CHK("ref a idle", 0, r)
    wb(1'b1, 8'h00, q);
    meas(12, 60, h, r);
    `CHK("ref a pass", 10, r)
    wb(1'b0, 8'h40, q);
    `CHK("unmapped", 32'h0000_0000, q)
    $display("test startup done");
  endtask : t_startup

  task automatic t_program;
    int h, r;
    logic [31:0] q, w;
    cdd_pkg::cdd_div_type d [5] = '{11'h001, 11'h002, 11'h003, 11'h01a, 11'h415};
    foreach (d[i])
    begin
      w = {16'h0000, d[i], 5'h01};
      send(w);
      send(w);
      wb(1'b0, 8'h08, q);
      `CHK("shift reg", w, q)
      wb(1'b0, 8'h84, q);
      `CHK("cfg word", {w[31:5], 5'h00}, q)
      wb(1'b0, 8'h04, q);
      `CHK("status", {5'h01, 4'h0, d[i] >= 11'h01a, 2'h1}, {q[12:8], q[7:4], q[3], q[1:0]})
      meas(3, 4 * d[i], h, r);
      `CHK("div rises", 4, r)
      `CHK("div duty", 4 * d[i], h)
    end
    $display("test program done");
  endtask : t_program

  task automatic t_ref;
    int h, r;
    for (int d = 1; d <= 8; d += 7)
    begin
      send({22'h00_0000, d == 8, 1'b1, 3'(d - 1), 5'h0a});
      repeat (100) @(posedge clk_sys);
      meas(12, 60 * d, h, r);
      `CHK("ref div rises", 10, r)
      `CHK("ref div duty", 60 * d, h)
      meas(13, d == 8 ? 480 : 60, h, r);
      `CHK("ref bypass", 10, r)
    end
    $display("test ref done");
  endtask : t_ref

  task automatic t_sync;
    int h, r, n;
    logic [31:0] q;
    cdd_pkg::cdd_half_pair_type a, b;
    send({16'h0000, 11'h004, 5'h00});
    send({16'h0000, 11'h006, 5'h01});
    send({15'h0000, 1'b1, 11'h003, 5'h02});
    sync_pin <= 1'b1;
    meas(4, 30, h, r);
    `CHK("exempt runs", 10, r)
    sync_pin <= 1'b0;
    n = 0;
    do begin @(posedge clk_sys); a = lanes[0]; b = lanes[2]; n++; end
    while (a.first_half !== 1'b1 && n < 50);
    `CHK("restart", 1'b1, a.first_half)
    `CHK("common edge", a, b)
    send({26'h000_0000, 1'b1, 5'h0b});
    wb(1'b0, 8'h04, q);
    `CHK("sync by invert", 1'b1, q[1])
    meas(0, 10, h, r);
    `CHK("invert holds", 0, h)
    send(32'h0000_000b);
    wb(1'b0, 8'h04, q);
    `CHK("sync off", 1'b0, q[1])
    $display("test sync done");
  endtask : t_sync

  task automatic t_reset_word;
    int h, r;
    logic [31:0] q;
    send({14'h0000, 1'b1, 1'b0, 11'h007, 5'h00});
    wb(1'b0, 8'h80, q);
    `CHK("default cfg", 32'h0000_0020, q)
    wb(1'b0, 8'h04, q);
    `CHK("unprogrammed", 1'b0, q[0])
    meas(0, 100, h, r);
    `CHK("lane0 stops", 0, r)
    $display("test reset word done");
  endtask : t_reset_word

  initial
  begin
    {clk_sys, rst, sync_pin, reference_input, start, wb_cyc, wb_stb, wb_we} = 8'h40;
    {wb_adr, wb_sel, wb_dat_w, word, rc} = '0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_startup;
    t_program;
    t_ref;
    t_sync;
    t_reset_word;
    end_of_test;
  end
endmodule : tb_top
